// file: hmt_trap_csrs.v
// Machine trap and interrupt state with AXI4-Lite register access
`default_nettype none
`include "hmt_defines.vh"
module hmt_trap_csrs (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire trap_take,
  input wire guest_page_fault,
  input wire implicit_fault,
  input wire [63:0] fault_gpa,
  input wire [63:0] implicit_gpa,
  input wire [63:0] trap_inst,
  input wire [1:0] trap_priv,
  input wire hyp_vm_access,
  input wire implicit_access,
  input wire [1:0] gst_root_zero,
  input wire [15:0] irq_hw_set,
  output reg [1:0] eff_priv_reg,
  output reg eff_virt_reg,
  output reg vs_stage_on_reg,
  output reg g_stage_on_reg,
  output reg sum_eff_reg,
  output reg vs_mxr_reg,
  output reg g_mxr_reg,
  output reg pmp_on_reg,
  output reg [15:0] irq_ready_reg
);
  parameter GUEST_EXT_IRQ_COUNT = 1;

  reg [15:0] pend_reg;
  reg [15:0] enab_reg;
  reg [15:0] mdeleg_reg;
  reg [15:0] hdeleg_reg;
  reg [63:0] tval2_reg;
  reg [63:0] tinst_reg;
  reg [11:0] ctrl_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg aw_have_reg;
  reg w_have_reg;

  wire [1:0] eff_priv;
  wire eff_virt;
  wire vs_on;
  wire g_on;
  wire sum_eff;
  wire vs_mxr;
  wire g_mxr;
  wire pmp_on;
  wire [63:0] tval2_val;
  wire [63:0] tinst_val;

  wire [15:0] forced = `HMT_FORCED_DELEG |
    ((GUEST_EXT_IRQ_COUNT != 0) ? `HMT_SGE_BIT : 16'h0000);
  wire [15:0] deleg_view = mdeleg_reg | forced;
  wire wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function [15:0] merge_lo;
    input [15:0] old;
    input [31:0] nw;
    input [3:0] strb;
    begin
      merge_lo = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  function [31:0] reg_read;
    input [7:0] a;
    begin
      case (a)
        `HMT_ADDR_PEND: reg_read = {16'h0000, pend_reg & `HMT_IRQ_IMPL};
        `HMT_ADDR_ENAB: reg_read = {16'h0000, enab_reg & `HMT_IRQ_IMPL};
        `HMT_ADDR_MDELEG: reg_read = {16'h0000, deleg_view & `HMT_IRQ_IMPL};
        `HMT_ADDR_HDELEG: reg_read = {16'h0000, hdeleg_reg & deleg_view};
        `HMT_ADDR_HPEND: reg_read = {16'h0000, pend_reg & deleg_view & `HMT_HYP_ALIAS};
        `HMT_ADDR_HENAB: reg_read = {16'h0000, enab_reg & deleg_view & `HMT_HYP_ALIAS};
        `HMT_ADDR_TVAL2_LO: reg_read = tval2_reg[`HMT_XL_LO];
        `HMT_ADDR_TVAL2_HI: reg_read = tval2_reg[`HMT_XL_HI];
        `HMT_ADDR_TINST_LO: reg_read = tinst_reg[`HMT_XL_LO];
        `HMT_ADDR_TINST_HI: reg_read = tinst_reg[`HMT_XL_HI];
        `HMT_ADDR_CTRL: reg_read = {20'h00000, ctrl_reg};
        `HMT_ADDR_STATUS: reg_read = {26'h0000000, pmp_on, g_on, vs_on, eff_virt, eff_priv};
        default: reg_read = 32'h00000000;
      endcase
    end
  endfunction

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a <= `HMT_ADDR_STATUS) && (a[1:0] == 2'h0);
    end
  endfunction

  wire [31:0] ctrl_merged = merge({20'h00000, ctrl_reg}, wdata_reg, wstrb_reg);
  // Top bits of the shifted address cannot be held
  wire [63:0] tval2_keep = `HMT_TVAL2_MASK;

  hmt_access_mode u_mode (
    .ctrl(ctrl_reg),
    .hyp_vm_access(hyp_vm_access),
    .implicit_access(implicit_access),
    .gst_root_zero({14'h0000, gst_root_zero}),
    .eff_priv(eff_priv),
    .eff_virt(eff_virt),
    .vs_stage_on(vs_on),
    .g_stage_on(g_on),
    .sum_eff(sum_eff),
    .vs_mxr(vs_mxr),
    .g_mxr(g_mxr),
    .pmp_on(pmp_on)
  );

  hmt_trap_capture u_cap (
    .guest_page_fault(guest_page_fault),
    .implicit_fault(implicit_fault),
    .fault_gpa(fault_gpa),
    .implicit_gpa(implicit_gpa),
    .trap_inst(trap_inst),
    .tval2_val(tval2_val),
    .tinst_val(tinst_val)
  );

  // Bus handshake: one write and one read at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HMT_RESP_OK;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `HMT_RESP_OK;
      s_axi_rdata <= 32'h00000000;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(awaddr_reg) ? `HMT_RESP_OK : `HMT_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= reg_read(s_axi_araddr);
        s_axi_rresp <= addr_ok(s_axi_araddr) ? `HMT_RESP_OK : `HMT_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Register state; hardware events win over a same-cycle software write
  always @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg <= 16'h0000;
      enab_reg <= 16'h0000;
      mdeleg_reg <= 16'h0000;
      hdeleg_reg <= 16'h0000;
      tval2_reg <= 64'h0;
      tinst_reg <= 64'h0;
      ctrl_reg <= 12'h000;
    end else begin
      if (wr_go) begin
        case (awaddr_reg)
          `HMT_ADDR_PEND:
            pend_reg <= merge_lo(pend_reg, wdata_reg, wstrb_reg) & `HMT_IRQ_IMPL;
          `HMT_ADDR_ENAB:
            enab_reg <= merge_lo(enab_reg, wdata_reg, wstrb_reg) & `HMT_IRQ_IMPL;
          `HMT_ADDR_MDELEG:
            mdeleg_reg <= merge_lo(mdeleg_reg, wdata_reg, wstrb_reg) & `HMT_IRQ_IMPL;
          `HMT_ADDR_HDELEG:
            hdeleg_reg <= merge_lo(hdeleg_reg, wdata_reg, wstrb_reg) & deleg_view;
          `HMT_ADDR_HPEND:
            pend_reg <= (pend_reg & ~(deleg_view & `HMT_HYP_ALIAS)) |
              (merge_lo(pend_reg, wdata_reg, wstrb_reg) & deleg_view & `HMT_HYP_ALIAS);
          `HMT_ADDR_HENAB:
            enab_reg <= (enab_reg & ~(deleg_view & `HMT_HYP_ALIAS)) |
              (merge_lo(enab_reg, wdata_reg, wstrb_reg) & deleg_view & `HMT_HYP_ALIAS);
          `HMT_ADDR_TVAL2_LO:
            tval2_reg[`HMT_XL_LO] <= merge(tval2_reg[`HMT_XL_LO], wdata_reg, wstrb_reg);
          `HMT_ADDR_TVAL2_HI:
            tval2_reg[`HMT_XL_HI] <= merge(tval2_reg[`HMT_XL_HI], wdata_reg, wstrb_reg)
              & tval2_keep[`HMT_XL_HI];
          `HMT_ADDR_TINST_LO:
            tinst_reg[`HMT_XL_LO] <= merge(tinst_reg[`HMT_XL_LO], wdata_reg, wstrb_reg);
          `HMT_ADDR_TINST_HI:
            tinst_reg[`HMT_XL_HI] <= merge(tinst_reg[`HMT_XL_HI], wdata_reg, wstrb_reg);
          `HMT_ADDR_CTRL:
            ctrl_reg <= ctrl_merged[11:0];
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
      if (irq_hw_set != 16'h0000)
        pend_reg <= pend_reg | (irq_hw_set & `HMT_IRQ_IMPL);
      if (trap_take) begin
        tval2_reg <= tval2_val;
        tinst_reg <= tinst_val;
        ctrl_reg[`HMT_CTRL_MPV] <= ctrl_reg[`HMT_CTRL_VIRT];
        ctrl_reg[`HMT_CTRL_MPP] <= trap_priv;
        ctrl_reg[`HMT_CTRL_VIRT] <= 1'b0;
        ctrl_reg[`HMT_CTRL_PRIV] <= `HMT_PRIV_M;
      end
    end
  end

  // Registered views for the memory pipeline
  always @(posedge aclk) begin
    if (!aresetn) begin
      eff_priv_reg <= `HMT_PRIV_M;
      eff_virt_reg <= 1'b0;
      vs_stage_on_reg <= 1'b0;
      g_stage_on_reg <= 1'b0;
      sum_eff_reg <= 1'b0;
      vs_mxr_reg <= 1'b0;
      g_mxr_reg <= 1'b0;
      pmp_on_reg <= 1'b1;
      irq_ready_reg <= 16'h0000;
    end else begin
      eff_priv_reg <= eff_priv;
      eff_virt_reg <= eff_virt;
      vs_stage_on_reg <= vs_on;
      g_stage_on_reg <= g_on;
      sum_eff_reg <= sum_eff;
      vs_mxr_reg <= vs_mxr;
      g_mxr_reg <= g_mxr;
      pmp_on_reg <= pmp_on;
      irq_ready_reg <= pend_reg & enab_reg & `HMT_IRQ_IMPL;
    end
  end
endmodule // hmt_trap_csrs
`default_nettype wire

// file: hmt_defines.vh
// Constants for the machine trap and interrupt state block
// Functional notes
// - Privilege-modify clear: explicit accesses use current mode and its normal translation.
// - Modify set, prior virt 0: user or supervisor access, single-stage translation.
// - Modify set, prior privilege 3: machine access, no translation, any virt.
// - Modify set, prior virt 1: guest user or supervisor, two-stage translation.
// - Guest supervisor access via modify uses guest copy of user page permit.
// - Hypervisor exec-readable bit relaxes both guest stage and G-stage.
// - Guest exec-readable bit relaxes guest stage only; G-stage read still needed.
// - Hypervisor VM loads/stores ignore modify bit; virt on, privilege from select.
// - Delegation bits 10, 6, 2 read as fixed ones.
// - With guest external interrupts present, delegation bit 12 is fixed one.
// - Undelegated bits read zero in hyp delegation, pending, enable; writes ignored.
// - Pending/enable bits 15:0 follow fixed layout; 15,14,8,4,0 read zero.
// - Guest pending/enable bits share storage with hypervisor pending/enable.
// - Guest page fault writes shifted guest address or zero; other traps zero.
// - Implicit guest-stage access fault records that implicit access address.
// - Misaligned or split fetch records address of faulting part.
// - Second trap value holds zero; other values legalised to holdable subset.
// - Trap instruction register is read/write and written on every machine trap.
// - Virt on: guest root then G-stage root; zero root means pass-through.
// - Virt on: untranslated accesses incl. guest page tables use G-stage only.
// - Machine memory protection checks apply in every virtualization mode.
// - Every machine trap records current virtualization mode in prior virt.
`ifndef HMT_DEFINES_VH
`define HMT_DEFINES_VH
`define HMT_ADDR_PEND 8'h00
`define HMT_ADDR_ENAB 8'h04
`define HMT_ADDR_MDELEG 8'h08
`define HMT_ADDR_HDELEG 8'h0c
`define HMT_ADDR_HPEND 8'h10
`define HMT_ADDR_HENAB 8'h14
`define HMT_ADDR_TVAL2_LO 8'h18
`define HMT_ADDR_TVAL2_HI 8'h1c
`define HMT_ADDR_TINST_LO 8'h20
`define HMT_ADDR_TINST_HI 8'h24
`define HMT_ADDR_CTRL 8'h28
`define HMT_ADDR_STATUS 8'h2c
`define HMT_IRQ_IMPL 16'h3eee
`define HMT_FORCED_DELEG 16'h0444
`define HMT_SGE_BIT 16'h1000
`define HMT_HYP_ALIAS 16'h1444
`define HMT_TVAL2_MASK 64'h3fff_ffff_ffff_ffff
`define HMT_PRIV_U 2'h0
`define HMT_PRIV_S 2'h1
`define HMT_PRIV_M 2'h3
`define HMT_XL_LO 31:0
`define HMT_XL_HI 63:32
`define HMT_RESP_OK 2'h0
`define HMT_RESP_ERR 2'h2
`define HMT_CTRL_MODIFY_PRIVILEGE_BIT 0
`define HMT_CTRL_MPV 1
`define HMT_CTRL_MPP 3:2
`define HMT_CTRL_MXR 4
`define HMT_CTRL_GMXR 5
`define HMT_CTRL_SUM 6
`define HMT_CTRL_GSUM 7
`define HMT_CTRL_SPVP 8
`define HMT_CTRL_VIRT 9
`define HMT_CTRL_PRIV 11:10
`endif

// file: hmt_access_mode.v
// Effective privilege and translation-stage selection for explicit accesses
`default_nettype none
`include "hmt_defines.vh"
module hmt_access_mode (
  input wire [11:0] ctrl,
  input wire hyp_vm_access,
  input wire implicit_access,
  input wire [15:0] gst_root_zero,
  output reg [1:0] eff_priv,
  output reg eff_virt,
  output reg vs_stage_on,
  output reg g_stage_on,
  output reg sum_eff,
  output reg vs_mxr,
  output reg g_mxr,
  output reg pmp_on
);
  reg [1:0] cur_priv;
  always @* begin
    cur_priv = ctrl[`HMT_CTRL_PRIV];
    eff_priv = cur_priv;
    eff_virt = ctrl[`HMT_CTRL_VIRT];
    if (hyp_vm_access) begin
      eff_virt = 1'b1;
      eff_priv = {1'b0, ctrl[`HMT_CTRL_SPVP]};
    end else if (ctrl[`HMT_CTRL_MODIFY_PRIVILEGE_BIT]) begin
      if (ctrl[`HMT_CTRL_MPP] == `HMT_PRIV_M) begin
        eff_priv = `HMT_PRIV_M;
        eff_virt = 1'b0;
      end else begin
        eff_priv = ctrl[`HMT_CTRL_MPP];
        eff_virt = ctrl[`HMT_CTRL_MPV];
      end
    end
    // Root registers zeroed make a stage pass-through
    vs_stage_on = eff_virt && !implicit_access && !gst_root_zero[0];
    g_stage_on = eff_virt && !gst_root_zero[1];
    if (eff_priv == `HMT_PRIV_M) begin
      vs_stage_on = 1'b0;
      g_stage_on = 1'b0;
    end
    sum_eff = (eff_virt && eff_priv == `HMT_PRIV_S) ? ctrl[`HMT_CTRL_GSUM]
                                                    : ctrl[`HMT_CTRL_SUM];
    vs_mxr = ctrl[`HMT_CTRL_MXR] | (eff_virt & ctrl[`HMT_CTRL_GMXR]);
    g_mxr = ctrl[`HMT_CTRL_MXR];
    pmp_on = 1'b1;
  end
endmodule // hmt_access_mode
`default_nettype wire

// file: hmt_trap_capture.v
// Trap-time values for second trap value and trap instruction
`default_nettype none
`include "hmt_defines.vh"
module hmt_trap_capture (
  input wire guest_page_fault,
  input wire implicit_fault,
  input wire [63:0] fault_gpa,
  input wire [63:0] implicit_gpa,
  input wire [63:0] trap_inst,
  output reg [63:0] tval2_val,
  output reg [63:0] tinst_val
);
  reg [63:0] gpa;
  always @* begin
    // The caller supplies the faulting part's address for split accesses
    gpa = implicit_fault ? implicit_gpa : fault_gpa;
    tval2_val = guest_page_fault ? ((gpa >> 2) & `HMT_TVAL2_MASK) : 64'h0;
    tinst_val = trap_inst;
  end
endmodule // hmt_trap_capture
`default_nettype wire

// file: hmt_trap_csrs_monitor.sv
// Port checker for the machine trap and interrupt state block
`default_nettype none
module hmt_trap_csrs_monitor #(parameter GUEST_EXT_IRQ_COUNT = 1) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic hyp_vm_access,
  input wire logic [1:0] eff_priv_reg,
  input wire logic eff_virt_reg,
  input wire logic vs_stage_on_reg,
  input wire logic g_stage_on_reg,
  input wire logic vs_mxr_reg,
  input wire logic g_mxr_reg,
  input wire logic pmp_on_reg,
  input wire logic [15:0] irq_ready_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  m_notrans_a: assert property (eff_priv_reg == 2'h3 |-> !vs_stage_on_reg && !g_stage_on_reg)
    else $error("machine access is translated");
  pmp_always_a: assert property (pmp_on_reg)
    else $error("memory protection dropped");
  gstage_virt_a: assert property (g_stage_on_reg |-> eff_virt_reg)
    else $error("second stage without virtualization");
  vm_virt_a: assert property (hyp_vm_access ##1 hyp_vm_access |-> eff_virt_reg && eff_priv_reg != 2'h3)
    else $error("vm access not virtualized");
  mxr_order_a: assert property (g_mxr_reg |-> vs_mxr_reg)
    else $error("second stage relaxed alone");
  irq_zero_a: assert property ((irq_ready_reg & 16'hc111) == 16'h0)
    else $error("reserved interrupt bit active");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid)
    else $error("read not answered");
  cover property (hyp_vm_access ##1 eff_virt_reg);
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  cover property (g_stage_on_reg && vs_stage_on_reg);
endmodule // hmt_trap_csrs_monitor
bind hmt_trap_csrs hmt_trap_csrs_monitor #(.GUEST_EXT_IRQ_COUNT(GUEST_EXT_IRQ_COUNT)) u_mon (.*);
`default_nettype wire

// file: test_hyp_machine_trap_csrs.sv
// Self-checking testbench for the machine trap and interrupt state block
`default_nettype none
module test_hyp_machine_trap_csrs;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, eff_priv_reg;
  logic trap_take = 1'b0, guest_page_fault = 1'b0, implicit_fault = 1'b0;
  logic hyp_vm_access = 1'b0, implicit_access = 1'b0;
  logic [63:0] fault_gpa = 64'h0000_00ab_cdef_1230, implicit_gpa = 64'h0000_0044_5566_7788;
  logic [63:0] trap_inst = 64'h0;
  logic [1:0] trap_priv = 2'h1, gst_root_zero = 2'h0;
  logic [15:0] irq_hw_set = 16'h0, irq_ready_reg;
  logic eff_virt_reg, vs_stage_on_reg, g_stage_on_reg, sum_eff_reg, vs_mxr_reg, g_mxr_reg;
  logic pmp_on_reg;
  int err_total = 0;
  int compares = 0;
  hmt_trap_csrs #(.GUEST_EXT_IRQ_COUNT(1)) u_hmt_trap_csrs (.*);
  always #2.5 aclk = ~aclk;
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    compares++;
    if ((got & m) !== (exp & m)) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask
  // Response ready stands from the request until the answer is sampled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    r = 2'h3;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 2'h3;
    d = 32'h0;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
    end
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, 32'h0, 32'h3);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk({30'h0, r}, 32'h0, 32'h3);
    chk(d, e, m);
  endtask
  task automatic t_reset;
    rchk(8'h2c, 32'h20, 32'h3f);
    rchk(8'h00, 32'h0, 32'hffff);
    rchk(8'h04, 32'h0, 32'hffff);
  endtask
  task automatic t_refuse;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h40, d, r);
    chk({30'h0, r}, 32'h2, 32'h3);
    chk(d, 32'h0, 32'hffffffff);
    wr(8'h02, 32'h1, r);
    chk({30'h0, r}, 32'h2, 32'h3);
  endtask
  task automatic t_irq;
    wchk(8'h08, 32'h0);
    rchk(8'h08, 32'h0444, 32'h0444);
    rchk(8'h08, 32'h1000, 32'h1000);
    wchk(8'h0c, 32'hffff);
    rchk(8'h0c, 32'h0, 32'hebbb);
    wchk(8'h14, 32'h1444);
    rchk(8'h04, 32'h1444, 32'h1444);
    wchk(8'h04, 32'h0);
    rchk(8'h14, 32'h0, 32'h1444);
    wchk(8'h04, 32'hffff);
    rchk(8'h04, 32'h0, 32'hc111);
    irq_hw_set <= 16'hffff;
    @(posedge aclk);
    irq_hw_set <= 16'h0;
    rchk(8'h00, 32'h0800, 32'hc911);
    rchk(8'h10, 32'h0, 32'hebbb);
    chk({16'h0, irq_ready_reg}, 32'h3eee, 32'hffff);
  endtask
  task automatic mrow(input logic [11:0] c, input logic [1:0] rz, input logic [1:0] acc,
                      input logic [7:0] e, input logic [7:0] m);
    logic [31:0] d;
    logic [1:0] r;
    gst_root_zero <= rz;
    {implicit_access, hyp_vm_access} <= acc;
    wchk(8'h28, {20'h0, c});
    rd(8'h2c, d, r);
    chk({24'h0, g_mxr_reg, vs_mxr_reg, sum_eff_reg, d[4:0]}, {24'h0, e}, {24'h0, m});
  endtask
  task automatic t_modes;
    mrow(12'hc06, 2'h0, 2'h0, 8'h03, 8'hff);
    mrow(12'hc01, 2'h0, 2'h0, 8'h00, 8'hf7);
    mrow(12'hc05, 2'h0, 2'h0, 8'h01, 8'hf7);
    mrow(12'hc0f, 2'h0, 2'h0, 8'h03, 8'hff);
    mrow(12'hc03, 2'h0, 2'h0, 8'h1c, 8'hff);
    mrow(12'hc87, 2'h0, 2'h0, 8'h3d, 8'hff);
    mrow(12'hc47, 2'h0, 2'h0, 8'h1d, 8'hff);
    mrow(12'hc17, 2'h0, 2'h0, 8'hdd, 8'hff);
    mrow(12'hc27, 2'h0, 2'h0, 8'h5d, 8'hff);
    mrow(12'hc07, 2'h3, 2'h0, 8'h05, 8'hff);
    mrow(12'h600, 2'h0, 2'h2, 8'h10, 8'h18);
    mrow(12'hd0f, 2'h0, 2'h1, 8'h1d, 8'hff);
  endtask
  task automatic trap(input logic gpf, input logic imp, input logic [63:0] inst,
                      input logic [63:0] e);
    guest_page_fault <= gpf;
    implicit_fault <= imp;
    trap_inst <= inst;
    trap_take <= 1'b1;
    @(posedge aclk);
    trap_take <= 1'b0;
    rchk(8'h18, e[31:0], 32'hffffffff);
    rchk(8'h1c, e[63:32], 32'hffffffff);
    rchk(8'h20, inst[31:0], 32'hffffffff);
    rchk(8'h24, inst[63:32], 32'hffffffff);
  endtask
  task automatic t_trap;
    {implicit_access, hyp_vm_access} <= 2'h0;
    wchk(8'h28, 32'h600);
    trap(1'b1, 1'b0, 64'h0000_0001_0000_3a07, fault_gpa >> 2);
    rchk(8'h28, 32'hc06, 32'hf0f);
    trap_priv <= 2'h0;
    trap(1'b1, 1'b1, 64'h0000_0000_0000_0013, implicit_gpa >> 2);
    rchk(8'h28, 32'hc00, 32'hf0f);
    trap(1'b0, 1'b0, 64'h0, 64'h0);
    wchk(8'h1c, 32'h1234_5678);
    rchk(8'h1c, 32'h1234_5678, 32'hffffffff);
    wchk(8'h1c, 32'hffff_ffff);
    rchk(8'h1c, 32'h3fff_ffff, 32'hffffffff);
    wchk(8'h1c, 32'h0);
    rchk(8'h1c, 32'h0, 32'hffffffff);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_refuse();
    t_irq();
    t_modes();
    t_trap();
    finish_test();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    finish_test();
  end
endmodule // test_hyp_machine_trap_csrs
`default_nettype wire
